// ===== verilog/fdrv_ctrl.sv
// Flash driver control: register bank, flash sequencer, timeout and zone logic.
// Assumes analog comparators for charge and sense zones and a host on the two-wire pins.
//
// Summary of operation
// - Bypass bit set: flash regardless of charge.
// - Bypass clear: no flash before end-of-charge.
// - End-of-charge flag follows target-reached comparator; held high in torch-only mode.
// - Torch code gives 60 to 200 mA.
// - Feedback code gives 30 to 100 mV.
// - Sensitivity bit: 0 edge, 1 level trigger.
// - Timeout 16 ms per step, top code 512 ms.
// - Headroom code gives 300 mV to 1 V.
// - Threshold code N trips at N/63 volts.
// - Zone enable turns three-zone control on.
// - No flash start above upper threshold.
// - Above lower threshold, current cut to 70%.
// - Below lower threshold, full flash current.
// - Zone change mid-flash changes current immediately.
`timescale 1ns/1ps
module fdrv_ctrl #(
    parameter int unsigned TIMEOUT_STEP_CYC = fdrv_pkg::TIMEOUT_ST_CY
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    // Two-wire host pins
    input  wire logic                        scl_i,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe_o,
    // Trigger and analog comparators
    input  wire logic                        strobe_i,
    input  wire logic                        cap_target_reached_i,
    input  wire logic                        sense_above_upper_i,
    input  wire logic                        sense_above_lower_i,
    // Analog settings
    output logic [2:0]                       torch_level_code_o,
    output logic [2:0]                       flash_feedback_code_o,
    output logic [2:0]                       headroom_code_o,
    output logic [fdrv_pkg::THR_W-1:0]       upper_threshold_code_o,
    output logic [fdrv_pkg::THR_W-1:0]       lower_threshold_code_o,
    output logic [1:0]                       charge_mode_o,
    output logic                             charge_en_o,
    output logic                             torch_en_o,
    output logic                             indicator_en_o,
    // Flash state
    output logic                             flash_on_o,
    output logic                             flash_reduced_o,
    output logic                             flash_timeout_o,
    output logic                             eoc_n_o
);
    import fdrv_pkg::*;

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (TIMEOUT_STEP_CYC < 1) begin : g_bad_step
        $error("TIMEOUT_STEP_CYC must be at least one");
    end

    logic [7:0] gp_q, cur_q, opt_q, hi_q, lo_q, rdata;
    logic       wr_stb;
    logic [7:0] ptr, wdata;
    logic [3:0] in_raw, in_m_q, in_s_q;
    logic       strobe_s, eoc_s, upper_s, lower_s, strobe_pv_q, strobe_rise;
    logic       flash_bit, flash_gate_bypass, zone_en, strobe_sensitivity_select, trig, start_ok, step_end, to_hit;
    fdrv_fl_e   fl_q, fl_d;
    logic [31:0] tick_q;
    logic [5:0] steps_q, to_limit;

    // ----------------------------------------------------------------
    // Host access
    // ----------------------------------------------------------------
    fdrv_serial_slave u_slave (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_oe_o (sda_oe_o),
        .wr_stb_o (wr_stb),
        .ptr_o    (ptr),
        .wdata_o  (wdata),
        .rdata_i  (rdata)
    );

    // Open-drain: only ever pulls low
    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
    end

    // Register writes; unmapped offsets are dropped silently
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gp_q  <= GEN_PURPOSE_RST;
            cur_q <= LED_CURRENT_RST;
            opt_q <= FLASH_OPTS_RST;
            hi_q  <= UPPER_ZONE_RST;
            lo_q  <= LOWER_ZONE_RST;
        end else if (wr_stb) begin
            case (ptr)
                GEN_PURPOSE_OFS: gp_q  <= wdata;
                LED_CURRENT_OFS: cur_q <= wdata;
                FLASH_OPTS_OFS:  opt_q <= wdata;
                UPPER_ZONE_OFS:  hi_q  <= wdata;
                LOWER_ZONE_OFS:  lo_q  <= wdata;
                default: ;
            endcase
        end
    end

    // Read mux; status shows live sequencer and comparator state
    always_comb begin
        case (ptr)
            GEN_PURPOSE_OFS:  rdata = gp_q;
            LED_CURRENT_OFS:  rdata = cur_q;
            FLASH_OPTS_OFS:   rdata = opt_q;
            UPPER_ZONE_OFS:   rdata = hi_q;
            LOWER_ZONE_OFS:   rdata = lo_q;
            FLASH_STATUS_OFS: rdata = {3'h0, flash_reduced_o, flash_on_o, eoc_s, lower_s, upper_s};
            default:          rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Field decode to analog settings
    // ----------------------------------------------------------------
    assign torch_level_code_o     = cur_q[CUR_TORCH_LSB +: 3];
    assign flash_feedback_code_o  = cur_q[CUR_FB_LSB +: 3];
    assign headroom_code_o        = opt_q[OPT_OH_LSB +: 3];
    assign upper_threshold_code_o = hi_q[THR_W-1:0];
    assign lower_threshold_code_o = lo_q[THR_W-1:0];
    assign charge_mode_o          = gp_q[GP_CMODE_LSB +: 2];
    assign charge_en_o            = gp_q[GP_CHARGE_BIT];
    assign torch_en_o             = gp_q[GP_TORCH_BIT];
    assign indicator_en_o         = gp_q[GP_IND_BIT];
    assign flash_bit              = gp_q[GP_FLASH_BIT];
    assign flash_gate_bypass                  = gp_q[GP_FLASH_GATE_BYPASS_BIT];
    assign zone_en                = gp_q[GP_ZONE_BIT];
    assign strobe_sensitivity_select                    = opt_q[OPT_SLE_BIT];

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    assign in_raw = {sense_above_lower_i, sense_above_upper_i, cap_target_reached_i, strobe_i};

    // Every pin and comparator is asynchronous to the clock
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                in_m_q[i] <= 1'b0;
                in_s_q[i] <= 1'b0;
            end else begin
                in_m_q[i] <= in_raw[i];
                in_s_q[i] <= in_m_q[i];
            end
        end
    end

    assign strobe_s = in_s_q[0];
    assign eoc_s    = in_s_q[1];
    assign upper_s  = in_s_q[2];
    assign lower_s  = in_s_q[3];

    // Edge detector reads the synchronised strobe only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strobe_pv_q <= 1'b0;
        end else begin
            strobe_pv_q <= strobe_s;
        end
    end

    assign strobe_rise = strobe_s & ~strobe_pv_q;

    // ----------------------------------------------------------------
    // Flash sequencer
    // ----------------------------------------------------------------
    assign trig     = strobe_sensitivity_select ? strobe_s : strobe_rise;
    assign start_ok = flash_bit & trig & (flash_gate_bypass | eoc_s)
                      & ~(zone_en & upper_s);
    assign to_limit = (opt_q[OPT_TO_LSB +: 4] == TO_CODE_LONG) ? TO_LONG_STEPS
                      : {2'h0, opt_q[OPT_TO_LSB +: 4]} + 6'h01;
    assign step_end = (tick_q == TIMEOUT_STEP_CYC - 32'h1);
    assign to_hit   = step_end & (steps_q == to_limit - 6'h01);

    // Next state; mode bit cleared by host aborts a running flash
    always_comb begin
        fl_d = fl_q;
        case (fl_q)
            FL_IDLE: begin
                if (start_ok) begin
                    fl_d = FL_ON;
                end
            end
            FL_ON: begin
                if (!flash_bit || (strobe_sensitivity_select && !strobe_s)) begin
                    fl_d = FL_IDLE;
                end else if (to_hit) begin
                    fl_d = strobe_sensitivity_select ? FL_HOLD : FL_IDLE;
                end
            end
            FL_HOLD: begin
                // Level trigger must drop before a new flash, so a stuck strobe cannot re-fire
                if (!flash_bit || !strobe_s) begin
                    fl_d = FL_IDLE;
                end
            end
            default: fl_d = FL_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fl_q <= FL_IDLE;
        end else begin
            fl_q <= fl_d;
        end
    end

    // Timeout counters run only while the flash is on
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || fl_q != FL_ON) begin
            tick_q  <= 32'h0;
            steps_q <= 6'h00;
        end else if (step_end) begin
            tick_q  <= 32'h0;
            steps_q <= steps_q + 6'h01;
        end else begin
            tick_q <= tick_q + 32'h1;
        end
    end

    // Registered flash outputs; zone is re-evaluated every cycle of a flash
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flash_on_o      <= 1'b0;
            flash_reduced_o <= 1'b0;
            flash_timeout_o <= 1'b0;
        end else begin
            flash_on_o      <= (fl_d == FL_ON);
            flash_reduced_o <= (fl_d == FL_ON) & zone_en & lower_s;
            flash_timeout_o <= (fl_q == FL_ON) & to_hit & flash_bit & ~(strobe_sensitivity_select & ~strobe_s);
        end
    end

    // Charge flag, active low; torch-only mode always reports charging
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            eoc_n_o <= 1'b1;
        end else begin
            eoc_n_o <= (gp_q[2:0] == MODE_TORCH) ? 1'b1 : ~eoc_s;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_bypass_starts: assert property ((fl_q == FL_IDLE) && flash_bit && trig && flash_gate_bypass && !(zone_en && upper_s)
                                      |=> flash_on_o)
        else $error("Flash did not start with bypass set");
    a_gate_needs_eoc: assert property ($rose(flash_on_o) && !$past(flash_gate_bypass) |-> $past(eoc_s))
        else $error("Flash started before end of charge");
    a_eoc_torch_mode: assert property ((gp_q[2:0] == MODE_TORCH) |=> eoc_n_o)
        else $error("Charge flag low in torch mode");
    a_edge_no_hold: assert property ((fl_q == FL_IDLE) && !strobe_sensitivity_select && !strobe_rise |=> !flash_on_o)
        else $error("Edge mode started without an edge");
    a_timeout_count: assert property (flash_timeout_o |-> $past(steps_q) == $past(to_limit) - 6'h01)
        else $error("Timeout at wrong step count");
    a_zone_off: assert property (!$past(zone_en) |-> !flash_reduced_o)
        else $error("Reduced current with zones off");
    a_upper_blocks: assert property ($rose(flash_on_o) |-> !$past(zone_en && upper_s))
        else $error("Flash started above upper threshold");
    a_lower_cuts: assert property (flash_on_o && $past(zone_en && lower_s) |-> flash_reduced_o)
        else $error("Current not cut above lower threshold");
    a_full_current: assert property (flash_on_o && !$past(lower_s) |-> !flash_reduced_o)
        else $error("Current cut below lower threshold");
    a_zone_follows: assert property (flash_on_o && $past(flash_on_o) && $past(zone_en) && $past(lower_s)
                                     && !$past(lower_s, 2)
                                     |-> flash_reduced_o && !$past(flash_reduced_o))
        else $error("Mid-flash zone change not followed");

endmodule

// ===== inc/fdrv_pkg.sv
// Constants shared by the flash driver control logic and its serial slave.
// Assumes a 20 MHz system clock and a two-wire host that only writes and reads bytes.
package fdrv_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TIMEOUT_ST_MS = 16;            // Timeout step in ms
    localparam int unsigned TIMEOUT_ST_CY = CLK_HZ / 1000 * TIMEOUT_ST_MS;
    localparam logic [3:0]  TO_CODE_LONG  = 4'hF;          // Code with the long timeout
    localparam logic [5:0]  TO_LONG_STEPS = 6'h20;         // 512 ms in 16 ms steps

    // ----------------------------------------------------------------
    // Serial slave
    // ----------------------------------------------------------------
    localparam logic [6:0]  SLAVE_ADDR    = 7'h53;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  GEN_PURPOSE_OFS  = 8'h10;
    localparam logic [7:0]  LED_CURRENT_OFS  = 8'hA0;
    localparam logic [7:0]  FLASH_OPTS_OFS   = 8'hB0;
    localparam logic [7:0]  UPPER_ZONE_OFS   = 8'hC0;
    localparam logic [7:0]  LOWER_ZONE_OFS   = 8'hD0;
    localparam logic [7:0]  FLASH_STATUS_OFS = 8'hE0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  GEN_PURPOSE_RST  = 8'h00;
    localparam logic [7:0]  LED_CURRENT_RST  = 8'hF8;
    localparam logic [7:0]  FLASH_OPTS_RST   = 8'h80;
    localparam logic [7:0]  UPPER_ZONE_RST   = 8'hF9;
    localparam logic [7:0]  LOWER_ZONE_RST   = 8'hC6;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned GP_TORCH_BIT  = 0;
    localparam int unsigned GP_CHARGE_BIT = 1;
    localparam int unsigned GP_FLASH_BIT  = 2;
    localparam int unsigned GP_CMODE_LSB  = 3;
    localparam int unsigned GP_FLASH_GATE_BYPASS_BIT  = 5;
    localparam int unsigned GP_ZONE_BIT   = 6;
    localparam int unsigned GP_IND_BIT    = 7;
    localparam int unsigned CUR_TORCH_LSB = 0;
    localparam int unsigned CUR_FB_LSB    = 3;
    localparam int unsigned OPT_SLE_BIT   = 0;
    localparam int unsigned OPT_TO_LSB    = 1;
    localparam int unsigned OPT_OH_LSB    = 5;
    localparam int unsigned THR_W         = 6;
    localparam logic [2:0]  MODE_TORCH    = 3'h1;          // Torch only, no charging

    // Flash sequencer states
    typedef enum logic [2:0] {
        FL_IDLE = 3'h1,
        FL_ON   = 3'h2,
        FL_HOLD = 3'h4
    } fdrv_fl_e;

    // Serial slave phases
    typedef enum logic [4:0] {
        PH_IDLE  = 5'h01,
        PH_ADDR  = 5'h02,
        PH_REG   = 5'h04,
        PH_WDATA = 5'h08,
        PH_RDATA = 5'h10
    } fdrv_ph_e;

endpackage

// ===== verilog/fdrv_serial_slave.sv
// Byte-wide two-wire slave: address match, register pointer, writes and reads.
// Assumes open-drain pins resolved outside; clock stretching is never used.
`timescale 1ns/1ps
module fdrv_serial_slave (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Two-wire pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_o,
    // Register side
    output logic            wr_stb_o,
    output logic [7:0]      ptr_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i
);
    import fdrv_pkg::*;

    logic [1:0] scl_sy_q, sda_sy_q;
    logic       scl_pv_q, sda_pv_q;
    logic       scl_rise, scl_fall, start_c, stop_c;
    fdrv_ph_e   ph_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q;

    // Pins come from another domain: two flops before any use
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_pv_q <= 1'b1;
            sda_pv_q <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[0], scl_i};
            sda_sy_q <= {sda_sy_q[0], sda_i};
            scl_pv_q <= scl_sy_q[1];
            sda_pv_q <= sda_sy_q[1];
        end
    end

    // Line events seen on the second flop only
    assign scl_rise = scl_sy_q[1] & ~scl_pv_q;
    assign scl_fall = ~scl_sy_q[1] & scl_pv_q;
    assign start_c  = scl_sy_q[1] & scl_pv_q & sda_pv_q & ~sda_sy_q[1];
    assign stop_c   = scl_sy_q[1] & scl_pv_q & ~sda_pv_q & sda_sy_q[1];

    // Byte engine; the data line only ever changes while the clock is low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ph_q     <= PH_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            sda_oe_o <= 1'b0;
            wr_stb_o <= 1'b0;
            ptr_o    <= 8'h00;
            wdata_o  <= 8'h00;
        end else begin
            wr_stb_o <= 1'b0;
            if (start_c) begin
                ph_q     <= PH_ADDR;
                cnt_q    <= 4'hF;                      // Clock fall after a start is no bit: wraps to zero
                sda_oe_o <= 1'b0;
            end else if (stop_c) begin
                ph_q     <= PH_IDLE;
                sda_oe_o <= 1'b0;
            end else if (ph_q != PH_IDLE) begin
                if (scl_rise) begin
                    if (cnt_q < 4'h8) begin
                        sh_q <= {sh_q[6:0], sda_sy_q[1]};
                    end else if (ph_q == PH_RDATA && sda_sy_q[1]) begin
                        ph_q <= PH_IDLE;               // Host did not acknowledge: stop sending
                    end
                end else if (scl_fall) begin
                    if (cnt_q == 4'h7) begin
                        cnt_q    <= 4'h8;
                        sda_oe_o <= (ph_q != PH_RDATA);
                        case (ph_q)
                            PH_ADDR: begin
                                if (sh_q[7:1] != SLAVE_ADDR) begin
                                    ph_q     <= PH_IDLE;
                                    sda_oe_o <= 1'b0;
                                end
                            end
                            PH_REG:   ptr_o <= sh_q;
                            PH_WDATA: begin
                                wdata_o  <= sh_q;
                                wr_stb_o <= 1'b1;
                            end
                            default: ;
                        endcase
                    end else if (cnt_q == 4'h8) begin
                        cnt_q    <= 4'h0;
                        sda_oe_o <= 1'b0;
                        case (ph_q)
                            PH_ADDR: begin
                                if (sh_q[0]) begin
                                    ph_q     <= PH_RDATA;
                                    tx_q     <= rdata_i;
                                    sda_oe_o <= ~rdata_i[7];
                                end else begin
                                    ph_q <= PH_REG;
                                end
                            end
                            PH_REG:   ph_q <= PH_WDATA;
                            PH_RDATA: begin
                                tx_q     <= rdata_i;
                                sda_oe_o <= ~rdata_i[7];
                            end
                            default: ;
                        endcase
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                        if (ph_q == PH_RDATA) begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_o <= ~tx_q[6];
                        end
                    end
                end
            end
        end
    end

endmodule

// ===== verif/fdrv_host_model.sv
// Two-wire host model: start, stop, register writes and single-byte reads.
// Assumes the bench resolves the data wire with a pull-up; a 1 here releases it.
`timescale 1ns/1ps
module fdrv_host_model (
    // Clock and resolved data wire
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Host-driven pins
    output logic      scl_o,
    output logic      sda_o
);
    import fdrv_pkg::*;
    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    initial {scl_o, sda_o} = 2'b11;
    // Six clocks a phase, above the four-clock minimum of the slave
    task automatic ph(input logic c, input logic v);
        scl_o <= c;
        sda_o <= v;
        repeat (6) @(posedge clk_i);
    endtask
    // Start for a=1, stop for a=0; data is set while the clock is low, then flips while it is high
    task automatic cond(input logic a);
        ph(1'b0, sda_o);
        ph(1'b0, a);
        ph(1'b1, a);
        ph(1'b1, ~a);
    endtask
    // Eight bits MSB first, then the acknowledge slot as the ninth bit
    task automatic xbyte(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, sda_o);
            ph(1'b0, b[i]);
            ph(1'b1, b[i]);
            r[i] = sda_i;
            ph(1'b1, b[i]);
        end
    endtask
    // Read goes through a repeated start; the host never acknowledges read data
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] v,
                        output logic [7:0] q, output logic ok);
        logic [8:0] r0, r1, r2, r3;
        cond(1'b1);
        xbyte({SLAVE_ADDR, 2'b01}, r0);
        xbyte({a, 1'b1}, r1);
        if (rd) cond(1'b1);
        xbyte(rd ? {SLAVE_ADDR, 2'b11} : {v, 1'b1}, r2);
        if (rd) xbyte(9'h1FF, r3);
        cond(1'b0);
        q = r3[8:1];
        ok = ~(r0[0] | r1[0] | r2[0]);
    endtask
endmodule

// ===== verif/test_flash_driver_control_regs.sv
// Self-checking bench for the flash driver control block.
// Assumes fdrv_host_model on the two-wire pins and an 8-clock timeout step.
`timescale 1ns/1ps
module test_flash_driver_control_regs;
    import fdrv_pkg::*;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    localparam int unsigned STEP = 8;  // Short step keeps timeouts cheap
    logic       clk = 1'b0, rst_n = 1'b0, strobe = 1'b0, cap = 1'b0, s_up = 1'b0, s_lo = 1'b0;
    logic       scl, hsda, oe, on, red, tmo, eoc_n, t, r1, r2, sdo, ce, te, ie;
    logic [1:0] cm;
    logic [2:0] tc, fc, hc;
    logic [5:0] uc, lc;
    int         bad_count = 0, n_compared = 0, d;
    wire        sda = oe ? 1'b0 : hsda;  // Pull-up unless the device sinks
    always #25 clk = ~clk;
    fdrv_host_model u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
    fdrv_ctrl #(.TIMEOUT_STEP_CYC(STEP)) u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .strobe_i(strobe),
        .cap_target_reached_i(cap), .sense_above_upper_i(s_up), .sense_above_lower_i(s_lo),
        .torch_level_code_o(tc), .flash_feedback_code_o(fc), .headroom_code_o(hc), .upper_threshold_code_o(uc),
        .lower_threshold_code_o(lc), .charge_mode_o(cm), .charge_en_o(ce), .torch_en_o(te), .indicator_en_o(ie),
        .flash_on_o(on), .flash_reduced_o(red), .flash_timeout_o(tmo), .eoc_n_o(eoc_n));
    task automatic print_verdict(input int extra);
        bad_count += extra;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Register access; a write is judged on its acknowledges only
    task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] v);
        logic       ok;
        logic [7:0] q;
        u_host.xfer(rd, a, v, q, ok);
        chk({ok, rd ? q : v}, {1'b1, v});
    endtask
    // Strobe held hold cycles, lower comparator toggled then if flip; on-time counted
    task automatic fire(input int hold, input logic flip);
        int k;
        d = 0;
        {t, r1, r2} = 3'h0;
        @(posedge clk);
        strobe <= 1'b1;
        for (k = 0; k < 600; k++) begin
            @(posedge clk);
            if (k == hold) begin
                strobe <= 1'b0;
                s_lo   <= s_lo ^ flip;
            end
            @(negedge clk);
            if (k == 20) r1 = red;
            if (on === 1'b1) begin
                d++;
                r2 = red;
            end else if (d > 0) begin
                t = tmo;
                break;
            end
        end
        if (k == 600 && d > 0) print_verdict(1);
        @(posedge clk);
        strobe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        acc(1'b1, GEN_PURPOSE_OFS, GEN_PURPOSE_RST);
        acc(1'b1, LED_CURRENT_OFS, LED_CURRENT_RST);
        acc(1'b1, FLASH_OPTS_OFS, FLASH_OPTS_RST);
        acc(1'b1, UPPER_ZONE_OFS, UPPER_ZONE_RST);
        acc(1'b1, LOWER_ZONE_OFS, LOWER_ZONE_RST);
        acc(1'b1, 8'h20, 8'h00);
        chk({tc, fc, hc}, 9'h03C);
        chk({uc, lc[2:0]}, 9'h1CE);
        $display("reset test done");
    endtask
    task automatic t_codes();
        for (int c = 0; c < 8; c++) begin
            acc(1'b0, LED_CURRENT_OFS, {2'h0, ~c[2:0], c[2:0]});
            acc(1'b0, FLASH_OPTS_OFS, {c[2:0], 5'h00});
            chk({tc, fc, hc}, {c[2:0], ~c[2:0], c[2:0]});
        end
        acc(1'b0, UPPER_ZONE_OFS, 8'h32);
        acc(1'b0, LOWER_ZONE_OFS, 8'h10);
        chk({uc, lc[5:3]}, 9'h192);
        $display("code test done");
    endtask
    task automatic t_flash();
        acc(1'b0, GEN_PURPOSE_OFS, 8'h04);
        acc(1'b0, FLASH_OPTS_OFS, 8'h00);
        fire(2, 1'b0);
        chk({eoc_n, d[7:0]}, 9'h100);
        cap <= 1'b1;
        repeat (6) @(posedge clk);
        chk({8'h00, eoc_n}, 9'h000);
        acc(1'b0, GEN_PURPOSE_OFS, 8'hD9);
        chk({2'h0, sdo, eoc_n, ie, cm, ce, te}, 9'h03D);
        acc(1'b0, GEN_PURPOSE_OFS, 8'h04);
        for (int c = 0; c < 16; c += 5) begin
            acc(1'b0, FLASH_OPTS_OFS, {3'h0, c[3:0], 1'b0});
            fire(2, 1'b0);
            chk(d[8:0], 9'((c == 15) ? 32 * STEP : STEP * (c + 1)));
            chk({8'h00, t}, 9'h001);
        end
        cap <= 1'b0;
        acc(1'b0, GEN_PURPOSE_OFS, 8'h24);
        fire(2, 1'b0);
        chk(d[8:0], 9'h100);
        acc(1'b0, FLASH_OPTS_OFS, 8'h1F);
        fire(20, 1'b0);
        chk({8'h00, d > 12 && d < 28}, 9'h001);
        acc(1'b0, FLASH_OPTS_OFS, 8'h01);
        fire(100, 1'b0);
        chk({t, d[7:0]}, 9'h108);
        $display("flash test done");
    endtask
    task automatic t_zone();
        acc(1'b0, GEN_PURPOSE_OFS, 8'h64);
        acc(1'b0, FLASH_OPTS_OFS, 8'h1E);
        s_up <= 1'b1;
        fire(2, 1'b0);
        chk(d[8:0], 9'h000);
        s_up <= 1'b0;
        s_lo <= 1'b1;
        fire(100, 1'b1);
        chk({7'h00, r1, r2}, 9'h002);
        fire(100, 1'b1);
        chk({7'h00, r1, r2}, 9'h001);
        acc(1'b0, GEN_PURPOSE_OFS, 8'h24);
        s_lo <= 1'b1;
        fire(100, 1'b0);
        chk({r1, r2, d[6:0]}, 9'h000);
        $display("zone test done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_codes();
        t_flash();
        t_zone();
        print_verdict(0);
    end
endmodule
